// [smmux_slave.sv]
// Two-wire send-byte slave that latches a multiplexer selection.
// Assumes scl/sda and straps arrive asynchronously; mclk_in is far
// faster than the serial clock so every edge is seen.
//
// Behaviour
// - Start, seven address bits and direction bit; address compared.
// - On address match with write direction, pull data low during the acknowledge clock.
// - Straps form low two address bits below a fixed prefix.
// - Shift in command byte, acknowledge it, hold without applying.
// - Upper nibble ignored; low nibble is enable and channel code.
// - Repeated start to another slave keeps command, latch unchanged.
// - Latch updates only at first stop after a good command.
// - Latch update opens all switches before closing the new one.
// - Enable zero turns all off; one closes only the coded switch.
// - Single-ended: three-bit code picks one of eight inputs.
// - Differential: upper two code bits pick pair; bit zero ignored.
// - Start is data falling while clock is high.
// - Stop is data rising while clock is high.
// - Data stays stable while clock is high.
// - Data bits sampled on rising clock edge.
// - Data line only pulled low, never driven high.
// - Previous switch opens within 1200 ns of the stop.
`timescale 1ns/1ns
`default_nettype none

module smmux_slave
  import smmux_pkg::*;
#(
  parameter bit DIFF_VARIANT = 1'b0
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  // Serial link
  input wire logic scl_in,
  input wire logic sda_in,
  output smmux_pkg::smmux_od_t sda_out,
  // Address straps
  input wire logic addr_strap_hi_in,
  input wire logic addr_strap_lo_in,
  // Switch controls
  output logic [7:0] analog_inputs_out,
  output smmux_pkg::smmux_sel_t sel_out,
  output logic [7:0] cmd_shift_out
);
  import smmux_pkg::*;

  // ******************************************************
  // Timing
  // ******************************************************
  // Longest time, rounded down
  localparam int TOFF_CYC = `SMMUX_TOFF_MAX_NS / `SMMUX_CLK_PERIOD_NS;
  // Least time, rounded up
  localparam int BBM_CYC =
    (`SMMUX_BBM_MIN_NS + `SMMUX_CLK_PERIOD_NS - 1) / `SMMUX_CLK_PERIOD_NS;
  // Counter width holds the full break count
  localparam int BBM_W = $clog2(BBM_CYC + 1);

  // ******************************************************
  // State
  // ******************************************************
  typedef struct packed {
    logic [1:0] scl_sync;
    logic [1:0] sda_sync;
    logic [1:0] strap_hi_sync;
    logic [1:0] strap_lo_sync;
    logic scl_d;
    logic sda_d;
    smmux_state_t st;
    logic [2:0] bit_cnt;
    logic byte_full;
    logic [7:0] shift;
    logic [7:0] cmd;
    logic cmd_valid;
    logic sda_pull;
    smmux_sw_t sw;
    logic [BBM_W-1:0] bbm_cnt;
    smmux_sel_t sel;
    logic [7:0] sw_on;
  } smmux_regs_t;

  // Whole state in one struct; one comb fill, one register stage
  smmux_regs_t q_r;
  smmux_regs_t q_nxt;

  // ******************************************************
  // Helpers
  // ******************************************************
  // Last bit of a byte on the three-bit counter
  localparam logic [2:0] BYTE_LAST = 3'h7;

  // Switch decode for a selection
  function automatic logic [7:0] decode_sel(input smmux_sel_t s);
    logic [7:0] v;
    v = 8'h00;
    if (s.en) begin
      if (DIFF_VARIANT) begin
        v[{1'b0, s.code[2:1]}] = 1'b1;
      end else begin
        v[s.code] = 1'b1;
      end
    end
    return v;
  endfunction : decode_sel

  // Two-stage synchroniser step for one pin
  function automatic logic [1:0] sync_step(input logic [1:0] s,
                                           input logic pin);
    return {s[0], pin};
  endfunction : sync_step

  // One data bit in, msb first
  function automatic logic [7:0] shift_in(input logic [7:0] s,
                                          input logic b);
    return {s[6:0], b};
  endfunction : shift_in

  // Clock fall that closes a full byte
  // Keeps the byte end test alike in both phases
  function automatic logic byte_end(input logic full, input logic fall);
    return full & fall;
  endfunction : byte_end

  function automatic logic addr_hit(input logic [7:0] s,
                                    input logic [6:0] a);
    return (s[7:1] == a) && !s[0];
  endfunction : addr_hit

  logic scl_s;
  logic sda_s;
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  logic [6:0] my_addr;

  // ******************************************************
  // Edge and condition detect
  // ******************************************************
  always_comb begin
    scl_s = q_r.scl_sync[1];
    sda_s = q_r.sda_sync[1];
    scl_rise = scl_s & ~q_r.scl_d;
    scl_fall = ~scl_s & q_r.scl_d;
    // Both samples need clock high, so a data move while the
    // clock falls is never taken for a start or stop
    // start detect
    start_cond = scl_s & q_r.scl_d & q_r.sda_d & ~sda_s;
    stop_cond = scl_s & q_r.scl_d & ~q_r.sda_d & sda_s;
    // Straps are read live; move them only between frames
    // strap address
    my_addr = {DIFF_VARIANT ? `SMMUX_ADDR_PREFIX_DIFF
                            : `SMMUX_ADDR_PREFIX_SE,
               q_r.strap_hi_sync[1], q_r.strap_lo_sync[1]};
  end

  // ******************************************************
  // Next state
  // ******************************************************
  always_comb begin
    q_nxt = q_r;
    // ******************************************************
    // Synchronisers
    // ******************************************************
    q_nxt.scl_sync = sync_step(q_r.scl_sync, scl_in);
    q_nxt.sda_sync = sync_step(q_r.sda_sync, sda_in);
    q_nxt.strap_hi_sync = sync_step(q_r.strap_hi_sync, addr_strap_hi_in);
    q_nxt.strap_lo_sync = sync_step(q_r.strap_lo_sync, addr_strap_lo_in);
    q_nxt.scl_d = scl_s;
    q_nxt.sda_d = sda_s;

    // ******************************************************
    // Frame decode
    // ******************************************************
    if (start_cond) begin
      q_nxt.st = SMMUX_ADDR;
      q_nxt.bit_cnt = 3'h0;
      q_nxt.byte_full = 1'b0;
      q_nxt.sda_pull = 1'b0;
    end else if (stop_cond) begin
      q_nxt.st = SMMUX_IDLE;
      q_nxt.bit_cnt = 3'h0;
      q_nxt.byte_full = 1'b0;
      q_nxt.sda_pull = 1'b0;
      if (q_r.cmd_valid) begin
        q_nxt.cmd_valid = 1'b0;
        q_nxt.sw_on = 8'h00;
        q_nxt.sw = SMMUX_SW_BREAK;
        q_nxt.bbm_cnt = '0;
        q_nxt.sel.en = q_r.cmd[`SMMUX_CMD_EN_BIT];
        q_nxt.sel.code = q_r.cmd[`SMMUX_CMD_CODE_MSB:`SMMUX_CMD_CODE_LSB];
      end
      // no update otherwise
      // A second stop finds the flag clear and leaves the latch
    end else begin
      unique case (q_r.st)
        SMMUX_IDLE: begin
          // Bus free; wait for a start
          q_nxt.sda_pull = 1'b0;
        end
        SMMUX_IGNORE: begin
          q_nxt.sda_pull = 1'b0;
        end
        SMMUX_ADDR: begin
          if (scl_rise) begin
            q_nxt.shift = shift_in(q_r.shift, sda_s);
            q_nxt.bit_cnt = q_r.bit_cnt + 3'h1;
            q_nxt.byte_full = (q_r.bit_cnt == BYTE_LAST);
          end
          // The fall just after the start is not a byte end
          if (byte_end(q_r.byte_full, scl_fall)) begin
            q_nxt.byte_full = 1'b0;
            if (addr_hit(q_r.shift, my_addr)) begin
              q_nxt.sda_pull = 1'b1;
              q_nxt.st = SMMUX_ADDR_ACK;
            end else begin
              q_nxt.st = SMMUX_IGNORE;
            end
          end
        end
        SMMUX_ADDR_ACK: begin
          // Line held low across the whole acknowledge high phase
          if (scl_fall) begin
            q_nxt.sda_pull = 1'b0;
            q_nxt.st = SMMUX_CMD;
          end
        end
        SMMUX_CMD: begin
          if (scl_rise) begin
            q_nxt.shift = shift_in(q_r.shift, sda_s);
            q_nxt.bit_cnt = q_r.bit_cnt + 3'h1;
            q_nxt.byte_full = (q_r.bit_cnt == BYTE_LAST);
          end
          if (byte_end(q_r.byte_full, scl_fall)) begin
            q_nxt.byte_full = 1'b0;
            q_nxt.sda_pull = 1'b1;
            q_nxt.cmd = q_r.shift;
            q_nxt.cmd_valid = 1'b1;
            q_nxt.st = SMMUX_CMD_ACK;
          end
        end
        SMMUX_CMD_ACK: begin
          // A start in this bit aborts; the command stays pending
          if (scl_fall) begin
            q_nxt.sda_pull = 1'b0;
            q_nxt.st = SMMUX_IGNORE;
          end
        end
      endcase
    end

    // ******************************************************
    // Break-before-make sequencer
    // ******************************************************
    // A fresh latch update this cycle owns the sequencer
    if (!(stop_cond && q_r.cmd_valid)) begin
      unique case (q_r.sw)
        SMMUX_SW_HOLD: begin
          // Nothing pending; switches follow the latch
          q_nxt.bbm_cnt = '0;
        end
        SMMUX_SW_BREAK: begin
          // all open for the break interval
          if (q_r.bbm_cnt == BBM_W'(BBM_CYC)) begin
            q_nxt.sw = SMMUX_SW_HOLD;
            q_nxt.sw_on = decode_sel(q_r.sel);
          end else begin
            q_nxt.bbm_cnt = q_r.bbm_cnt + BBM_W'(1);
          end
        end
      endcase
    end
  end

  // ******************************************************
  // Registers
  // ******************************************************
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      q_r <= '0;
      q_r.scl_sync <= 2'h3;
      q_r.sda_sync <= 2'h3;
      q_r.scl_d <= 1'b1;
      q_r.sda_d <= 1'b1;
      q_r.st <= SMMUX_IDLE;
      q_r.sw <= SMMUX_SW_HOLD;
      // Bus released, nothing pending, no switch closed
      q_r.bit_cnt <= 3'h0;
      q_r.byte_full <= 1'b0;
      q_r.cmd_valid <= 1'b0;
      q_r.sda_pull <= 1'b0;
      q_r.sw_on <= 8'h00;
      q_r.sel <= `SMMUX_LATCH_RESET;
    end else begin
      q_r <= q_nxt;
    end
  end

  // ******************************************************
  // Outputs
  // ******************************************************
  // open drain, low only
  assign sda_out.o = 1'b0;
  assign sda_out.oe = q_r.sda_pull;
  assign analog_inputs_out = q_r.sw_on;
  assign sel_out = q_r.sel;
  assign cmd_shift_out = q_r.cmd;

  // ******************************************************
  // Off-time margin
  // ******************************************************
  // TOFF_CYC bounds the off delay; one cycle is used
  logic unused_toff;
  assign unused_toff = (TOFF_CYC < 1);

endmodule : smmux_slave

`default_nettype wire

// [smmux_defines.svh]
// Constants for the serial multiplexer select slave.
// Included by the package and the bench; definitions only.
`ifndef SMMUX_DEFINES_SVH
`define SMMUX_DEFINES_SVH

// Address prefix above the two strap bits (7-bit form)
`define SMMUX_ADDR_PREFIX_SE 5'h12
`define SMMUX_ADDR_PREFIX_DIFF 5'h13
// Command byte fields
`define SMMUX_CMD_EN_BIT 3
`define SMMUX_CMD_CODE_MSB 2
`define SMMUX_CMD_CODE_LSB 0
`define SMMUX_LATCH_RESET 4'h0
// Timing
`define SMMUX_CLK_PERIOD_NS 4
`define SMMUX_TOFF_MAX_NS 1200
`define SMMUX_BBM_MIN_NS 75

`endif

// [smmux_pkg.sv]
// Types for the serial multiplexer select slave.
// Needs smmux_defines.svh on the include path.
`include "smmux_defines.svh"

package smmux_pkg;

  typedef enum logic [2:0] {
    SMMUX_IDLE,
    SMMUX_ADDR,
    SMMUX_ADDR_ACK,
    SMMUX_CMD,
    SMMUX_CMD_ACK,
    SMMUX_IGNORE
  } smmux_state_t;

  typedef enum logic [1:0] {
    SMMUX_SW_HOLD,
    SMMUX_SW_BREAK
  } smmux_sw_t;

  // Open-drain pin as seen by the design
  typedef struct packed {
    logic o;
    logic oe;
  } smmux_od_t;

  // Latched selection: enable plus channel code
  typedef struct packed {
    logic en;
    logic [2:0] code;
  } smmux_sel_t;

endpackage : smmux_pkg

// [smmux_asserts.sv]
// Port checker for the mux select slave, single-ended variant.
// Bound into smmux_slave; sees its ports only.
`timescale 1ns/1ns
`default_nettype none

module smmux_asserts
  import smmux_pkg::*;
(
  // Clock and reset
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  // Serial link and switch state
  input wire logic scl_in,
  input wire smmux_pkg::smmux_od_t sda_out,
  input wire logic [7:0] analog_inputs_out,
  input wire smmux_pkg::smmux_sel_t sel_out,
  input wire logic [7:0] cmd_shift_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (sys_rst_in);
  logic [7:0] one_hot;
  assign one_hot = 8'h01 << sel_out.code;
  sequence s_open;
    analog_inputs_out == 8'h00;
  endsequence
  sequence s_shut;
    analog_inputs_out == one_hot;
  endsequence
  property p_od; sda_out.o == 1'b0; endproperty
  a_od: assert property (p_od) else $error("sda driven high");
  property p_dis; !sel_out.en |-> s_open; endproperty
  a_dis: assert property (p_dis) else $error("switch on, en low");
  property p_hot; analog_inputs_out != 8'h00 |-> sel_out.en ##0 s_shut;
  endproperty
  a_hot: assert property (p_hot) else $error("wrong switch");
  property p_off; $changed(sel_out) |-> s_open; endproperty
  a_off: assert property (p_off) else $error("late open");
  property p_bbm; $changed(sel_out) |=> s_open [*8]; endproperty
  a_bbm: assert property (p_bbm) else $error("make before break");
  property p_close;
    $changed(sel_out) && sel_out.en |-> s_open [*8] ##[8:30] s_shut;
  endproperty
  a_close: assert property (p_close) else $error("no close");
  property p_copy; $changed(sel_out) |-> sel_out == cmd_shift_out[3:0];
  endproperty
  a_copy: assert property (p_copy) else $error("bad latch");
  property p_hold; $changed(cmd_shift_out) |-> $stable(sel_out); endproperty
  a_hold: assert property (p_hold) else $error("early apply");
  property p_ack_on; $rose(sda_out.oe) |-> !scl_in; endproperty
  a_ack_on: assert property (p_ack_on) else $error("ack rise");
  property p_ack_off; $fell(sda_out.oe) |-> !scl_in; endproperty
  a_ack_off: assert property (p_ack_off) else $error("ack fall");
endmodule : smmux_asserts

bind smmux_slave smmux_asserts u_chk (.mclk_in, .sys_rst_in, .scl_in,
  .sda_out, .analog_inputs_out, .sel_out, .cmd_shift_out);
`default_nettype wire

// [smmux_host.sv]
// Bus host model: makes the serial clock, drives data open-drain.
// Assumes sda_in is the resolved line with a pull-up.
`timescale 1ns/1ns
`default_nettype none

module smmux_host (
  // Bench clock
  input wire logic clk_in,
  // Serial link
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_out
);
  // Clock stands high between frames
  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end
  task automatic tk(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : tk
  task automatic start();
    sda_out = 1'b1;
    tk(5);
    scl_out = 1'b1;
    tk(5);
    sda_out = 1'b0;
    tk(5);
    scl_out = 1'b0;
    tk(5);
  endtask : start
  task automatic stop();
    sda_out = 1'b0;
    tk(5);
    scl_out = 1'b1;
    tk(5);
    sda_out = 1'b1;
    tk(5);
  endtask : stop
  task automatic bit_x(input logic b, output logic r);
    sda_out = b;
    tk(5);
    scl_out = 1'b1;
    tk(5);
    r = sda_in;
    tk(5);
    scl_out = 1'b0;
    tk(5);
  endtask : bit_x
  // msb first, then released for ack
  task automatic put_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], r);
    end
    bit_x(1'b1, ack);
  endtask : put_byte
endmodule : smmux_host
`default_nettype wire

// [tb_top.sv]
// Self-checking bench for the mux select slave.
// Host model drives the link; queue feeds the latch monitor.
`include "smmux_defines.svh"
`timescale 1ns/1ns
`default_nettype none

module tb_top;
  import smmux_pkg::*;
  logic mclk = 1'b0, rst = 1'b1, hi = 1'b0, lo = 1'b0, scl, sda_h, ack;
  logic [7:0] sw, sh, lf = 8'h1f;
  logic [3:0] q[$], e;
  smmux_od_t od;
  smmux_sel_t sel;
  int err_count = 0, cmp_count = 0, cyc = 0;
  wire sda = sda_h & ~od.oe;
  always #2 mclk = ~mclk;
  smmux_host u_host (.clk_in(mclk), .sda_in(sda), .scl_out(scl),
    .sda_out(sda_h));
  smmux_slave u_dut (.mclk_in(mclk), .sys_rst_in(rst), .scl_in(scl),
    .sda_in(sda), .sda_out(od), .addr_strap_hi_in(hi),
    .addr_strap_lo_in(lo), .analog_inputs_out(sw), .sel_out(sel),
    .cmd_shift_out(sh));
  function automatic logic [7:0] nx(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction : nx
  task automatic chk(input string n, input logic [7:0] s, e);
    cmp_count++;
    if (s !== e) begin
      err_count++;
      $display("MISMATCH %s exp %h saw %h", n, e, s);
    end
  endtask : chk
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : tally_and_finish
  task automatic txn(input logic [6:0] a, input logic rw,
    input logic [7:0] c, input logic ea);
    u_host.start();
    u_host.put_byte({a, rw}, ack);
    chk("ack_a", {7'h0, ack}, {7'h0, ea});
    u_host.put_byte(c, ack);
    chk("ack_c", {7'h0, ack}, {7'h0, ea});
  endtask : txn
  // An empty queue turns any latch change into a mismatch
  always @(sel) begin
    if (!rst) begin
      e = (q.size() > 0) ? q.pop_front() : 4'hx;
      chk("sel", {4'h0, sel}, {4'h0, e});
      repeat (22) @(posedge mclk);
      chk("sw", sw, e[3] ? 8'h01 << e[2:0] : 8'h00);
    end
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 40000) begin
      err_count++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (3) @(posedge mclk);
    #1 rst = 1'b0;
    u_host.tk(4);
    chk("sel_rst", {4'h0, sel}, 8'h00);
    chk("sw_rst", sw, 8'h00);
    for (int i = 1; i < 16; i++) begin
      {hi, lo} = i[1:0];
      lf = nx(lf);
      u_host.tk(5);
      txn({`SMMUX_ADDR_PREFIX_SE, hi, lo}, 1'b0, {lf[7:4], i[3:0]}, 1'b0);
      chk("shift", sh, {lf[7:4], i[3:0]});
      q.push_back(i[3:0]);
      u_host.stop();
    end
    u_host.tk(40);
    $display("test select done");
    txn({`SMMUX_ADDR_PREFIX_SE, ~hi, lo}, 1'b0, 8'h00, 1'b1);
    u_host.stop();
    txn({`SMMUX_ADDR_PREFIX_SE, hi, lo}, 1'b1, 8'h00, 1'b1);
    u_host.stop();
    $display("test refuse done");
    txn({`SMMUX_ADDR_PREFIX_SE, hi, lo}, 1'b0, 8'ha5, 1'b0);
    u_host.start();
    u_host.put_byte({`SMMUX_ADDR_PREFIX_DIFF, hi, lo, 1'b0}, ack);
    chk("ack_sr", {7'h0, ack}, 8'h01);
    chk("held", sh, 8'ha5);
    q.push_back(4'h5);
    u_host.stop();
    $display("test pending done");
    u_host.start();
    u_host.put_byte({`SMMUX_ADDR_PREFIX_SE, hi, lo, 1'b0}, ack);
    u_host.stop();
    u_host.tk(40);
    chk("sel_keep", {4'h0, sel}, 8'h05);
    $display("test early stop done");
    tally_and_finish();
  end
endmodule : tb_top
`default_nettype wire
